// ---- hw/aucr_regs.v ----
// Upper configuration register bank of the sigma-delta converter
`timescale 1ns/1ps
`include "aucr_map.vh"

module aucr_regs (
    input wire clk, // 100 MHz system clock
    input wire reset_n, // Asynchronous reset, active low
    input wire reg_wr, // Register write command strobe
    input wire reg_rd, // Register read command strobe
    input wire [7:0] reg_addr, // Register address
    input wire [7:0] reg_wdata, // Write data
    output reg [7:0] reg_rdata, // Read data
    output reg reg_rvalid, // Read data valid pulse
    input wire [2:0] gain_prog, // Programmed amplifier gain code
    output wire [2:0] gain_eff, // Effective amplifier gain code
    output wire mux_open, // Open analog input switches
    output wire ref_monitor_enable, // External reference monitor on
    output wire pos_ref_buffer_bypass, // Positive reference buffer bypassed
    output wire neg_ref_buffer_bypass, // Negative reference buffer bypassed
    output wire [1:0] ref_source_select, // Reference source code
    output wire [1:0] internal_ref_config, // Internal reference mode
    output wire [3:0] current_magnitude, // Common excitation current level
    output wire [3:0] first_current_route, // First source output channel
    output wire [3:0] second_current_route, // Second source output channel
    output wire [6:0] bias_voltage, // Bias switches, bit 6 common input
    output wire [2:0] system_monitor_select, // System monitor code
    output reg [4:0] calibration_sample_count, // Samples averaged in calibration
    output wire timeout_enable, // Serial timeout function enabled
    output wire [15:0] offset_trim_value, // Offset calibration word
    output wire [15:0] gain_trim_value, // Gain calibration word
    output reg conv_restart, // Conversion restart pulse
    input wire [3:0] pin_in, // Sensed pin levels
    output wire [3:0] pin_out, // Pin output levels
    output wire [3:0] pin_oe_n, // Pin output enables, low drives
    output wire [3:0] pin_function // 1 digital pin, 0 analog input
);

    // ************************************************************
    // Storage
    // ************************************************************
    reg [7:0] ref_q;
    reg [7:0] current_magnitude_q;
    reg [7:0] iroute_q;
    reg [7:0] bias_q;
    reg [7:0] sys_q;
    reg [7:0] ofs_lo_q;
    reg [7:0] ofs_hi_q;
    reg [7:0] gain_lo_q;
    reg [7:0] gain_hi_q;
    reg [7:0] pin_q;
    reg [7:0] pinfn_q;
    reg [7:0] rdata_d;
    reg restart_d;
    wire [3:0] pin_sensed;
    wire [3:0] pin_drive;

    // ************************************************************
    // Write path
    // ************************************************************
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ref_q <= `AUCR_RST_REF;
            current_magnitude_q <= `AUCR_RST_CURRENT_MAGNITUDE;
            iroute_q <= `AUCR_RST_IROUTE;
            bias_q <= `AUCR_RST_BIAS;
            sys_q <= `AUCR_RST_SYS;
            ofs_lo_q <= `AUCR_RST_OFS_LO;
            ofs_hi_q <= `AUCR_RST_OFS_HI;
            gain_lo_q <= `AUCR_RST_GAIN_LO;
            gain_hi_q <= `AUCR_RST_GAIN_HI;
            pin_q <= `AUCR_RST_PIN;
            pinfn_q <= `AUCR_RST_PINFN;
        end else if (reg_wr) begin
            if (reg_addr == `AUCR_ADDR_REF) begin
                ref_q <= reg_wdata & `AUCR_MASK_REF;
            end else if (reg_addr == `AUCR_ADDR_CURRENT_MAGNITUDE) begin
                current_magnitude_q <= reg_wdata & `AUCR_MASK_CURRENT_MAGNITUDE;
            end else if (reg_addr == `AUCR_ADDR_IROUTE) begin
                iroute_q <= reg_wdata;
            end else if (reg_addr == `AUCR_ADDR_BIAS) begin
                bias_q <= reg_wdata & `AUCR_MASK_BIAS;
            end else if (reg_addr == `AUCR_ADDR_SYS) begin
                sys_q <= reg_wdata & `AUCR_MASK_SYS;
            end else if (reg_addr == `AUCR_ADDR_OFS_LO) begin
                ofs_lo_q <= reg_wdata;
            end else if (reg_addr == `AUCR_ADDR_OFS_HI) begin
                ofs_hi_q <= reg_wdata;
            end else if (reg_addr == `AUCR_ADDR_GAIN_LO) begin
                gain_lo_q <= reg_wdata;
            end else if (reg_addr == `AUCR_ADDR_GAIN_HI) begin
                gain_hi_q <= reg_wdata;
            end else if (reg_addr == `AUCR_ADDR_PIN) begin
                pin_q <= reg_wdata;
            end else if (reg_addr == `AUCR_ADDR_PINFN) begin
                pinfn_q <= reg_wdata & `AUCR_MASK_PINFN;
            end
        end
    end

    // ************************************************************
    // Conversion restart
    // ************************************************************
    // Analog setup registers restart; trims and pins do not
    always @* begin
        restart_d = 1'b0;
        if (reg_wr) begin
            if (reg_addr == `AUCR_ADDR_REF) begin
                restart_d = 1'b1;
            end else if (reg_addr == `AUCR_ADDR_CURRENT_MAGNITUDE) begin
                restart_d = 1'b1;
            end else if (reg_addr == `AUCR_ADDR_IROUTE) begin
                restart_d = 1'b1;
            end else if (reg_addr == `AUCR_ADDR_BIAS) begin
                restart_d = 1'b1;
            end else if (reg_addr == `AUCR_ADDR_SYS) begin
                restart_d = 1'b1;
            end
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            conv_restart <= 1'b0;
        end else begin
            conv_restart <= restart_d;
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    // Inputs report the pin, outputs echo the written level
    assign pin_sensed = (pin_in & pin_q[7:4]) | (pin_q[3:0] & ~pin_q[7:4]);

    always @* begin
        rdata_d = 8'h00;
        if (reg_addr == `AUCR_ADDR_REF) begin
            rdata_d = ref_q;
        end else if (reg_addr == `AUCR_ADDR_CURRENT_MAGNITUDE) begin
            rdata_d = current_magnitude_q;
        end else if (reg_addr == `AUCR_ADDR_IROUTE) begin
            rdata_d = iroute_q;
        end else if (reg_addr == `AUCR_ADDR_BIAS) begin
            rdata_d = bias_q;
        end else if (reg_addr == `AUCR_ADDR_SYS) begin
            rdata_d = sys_q;
        end else if (reg_addr == `AUCR_ADDR_OFS_LO) begin
            rdata_d = ofs_lo_q;
        end else if (reg_addr == `AUCR_ADDR_OFS_HI) begin
            rdata_d = ofs_hi_q;
        end else if (reg_addr == `AUCR_ADDR_GAIN_LO) begin
            rdata_d = gain_lo_q;
        end else if (reg_addr == `AUCR_ADDR_GAIN_HI) begin
            rdata_d = gain_hi_q;
        end else if (reg_addr == `AUCR_ADDR_PIN) begin
            rdata_d = {pin_q[7:4], pin_sensed};
        end else if (reg_addr == `AUCR_ADDR_PINFN) begin
            rdata_d = pinfn_q;
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rdata_d;
            end
        end
    end

    // ************************************************************
    // Reference and excitation controls
    // ************************************************************
    assign ref_monitor_enable = ref_q[`AUCR_REF_MON_BIT];
    assign pos_ref_buffer_bypass = ref_q[`AUCR_REF_POSBUF_BIT];
    assign neg_ref_buffer_bypass = ref_q[`AUCR_REF_NEGBUF_BIT];
    assign ref_source_select = ref_q[`AUCR_REF_SEL_HI:`AUCR_REF_SEL_LO];
    assign internal_ref_config = ref_q[`AUCR_REF_CFG_HI:`AUCR_REF_CFG_LO];
    assign current_magnitude = current_magnitude_q[3:0];
    assign first_current_route = iroute_q[3:0];
    assign second_current_route = iroute_q[7:4];
    assign bias_voltage = bias_q[6:0];

    // ************************************************************
    // System monitor and calibration
    // ************************************************************
    assign system_monitor_select = sys_q[`AUCR_SYSTEM_MONITOR_SELECT_HI:`AUCR_SYSTEM_MONITOR_SELECT_LO];
    assign timeout_enable = sys_q[`AUCR_SYS_TMO_BIT];

    assign gain_eff = ((system_monitor_select == `AUCR_MON_ASUP) ||
                       (system_monitor_select == `AUCR_MON_DSUP)) ?
                      `AUCR_GAIN_ONE : gain_prog;

    assign mux_open = (system_monitor_select == `AUCR_MON_MID) ||
                      (system_monitor_select == `AUCR_MON_TEMP) ||
                      (system_monitor_select == `AUCR_MON_ASUP) ||
                      (system_monitor_select == `AUCR_MON_DSUP);

    always @* begin
        case (sys_q[`AUCR_SYS_CAL_HI:`AUCR_SYS_CAL_LO])
            2'h0: calibration_sample_count = `AUCR_CAL_N0;
            2'h1: calibration_sample_count = `AUCR_CAL_N1;
            2'h2: calibration_sample_count = `AUCR_CAL_N2;
            default: calibration_sample_count = `AUCR_CAL_N3;
        endcase
    end

    assign offset_trim_value = {ofs_hi_q, ofs_lo_q};
    assign gain_trim_value = {gain_hi_q, gain_lo_q};

    // ************************************************************
    // General-purpose pins
    // ************************************************************
    // Drive only digital pins set as outputs
    assign pin_drive = pinfn_q[3:0] & ~pin_q[7:4];
    assign pin_oe_n = ~pin_drive;
    assign pin_out = pin_q[3:0];
    assign pin_function = pinfn_q[3:0];

endmodule

// ---- hw/aucr_map.vh ----
// Offsets, field positions and reset values of the upper configuration registers
`ifndef AUCR_MAP_VH
`define AUCR_MAP_VH

// Register offsets
`define AUCR_ADDR_REF 8'h05
`define AUCR_ADDR_CURRENT_MAGNITUDE 8'h06
`define AUCR_ADDR_IROUTE 8'h07
`define AUCR_ADDR_BIAS 8'h08
`define AUCR_ADDR_SYS 8'h09
`define AUCR_ADDR_SPARE_A 8'h0a
`define AUCR_ADDR_OFS_LO 8'h0b
`define AUCR_ADDR_OFS_HI 8'h0c
`define AUCR_ADDR_SPARE_D 8'h0d
`define AUCR_ADDR_GAIN_LO 8'h0e
`define AUCR_ADDR_GAIN_HI 8'h0f
`define AUCR_ADDR_PIN 8'h10
`define AUCR_ADDR_PINFN 8'h11

// Reset values
`define AUCR_RST_REF 8'h10
`define AUCR_RST_CURRENT_MAGNITUDE 8'h00
`define AUCR_RST_IROUTE 8'hff
`define AUCR_RST_BIAS 8'h00
`define AUCR_RST_SYS 8'h10
`define AUCR_RST_OFS_LO 8'h00
`define AUCR_RST_OFS_HI 8'h00
`define AUCR_RST_GAIN_LO 8'h00
`define AUCR_RST_GAIN_HI 8'h40
`define AUCR_RST_PIN 8'h00
`define AUCR_RST_PINFN 8'h00

// Writable bit masks
`define AUCR_MASK_REF 8'h7f
`define AUCR_MASK_CURRENT_MAGNITUDE 8'h0f
`define AUCR_MASK_BIAS 8'h7f
`define AUCR_MASK_SYS 8'hfc
`define AUCR_MASK_PINFN 8'h0f

// Field positions
`define AUCR_REF_MON_BIT 6
`define AUCR_REF_POSBUF_BIT 5
`define AUCR_REF_NEGBUF_BIT 4
`define AUCR_REF_SEL_HI 3
`define AUCR_REF_SEL_LO 2
`define AUCR_REF_CFG_HI 1
`define AUCR_REF_CFG_LO 0
`define AUCR_SYSTEM_MONITOR_SELECT_HI 7
`define AUCR_SYSTEM_MONITOR_SELECT_LO 5
`define AUCR_SYS_CAL_HI 4
`define AUCR_SYS_CAL_LO 3
`define AUCR_SYS_TMO_BIT 2

// Monitor and gain codes
`define AUCR_MON_OFF 3'h0
`define AUCR_MON_MID 3'h1
`define AUCR_MON_TEMP 3'h2
`define AUCR_MON_ASUP 3'h3
`define AUCR_MON_DSUP 3'h4
`define AUCR_GAIN_ONE 3'h0

// Calibration sample counts
`define AUCR_CAL_N0 5'h01
`define AUCR_CAL_N1 5'h04
`define AUCR_CAL_N2 5'h08
`define AUCR_CAL_N3 5'h10

`endif

// ---- verif/aucr_regs_monitor.sv ----
// Port checker of the upper configuration register bank
`timescale 1ns/1ps
module aucr_regs_monitor (
    input wire clk, // Clock
    input wire reset_n, // Reset, active low
    input wire reg_wr, // Write strobe
    input wire reg_rd, // Read strobe
    input wire [7:0] reg_addr, // Address
    input wire [7:0] reg_wdata, // Write data
    input wire [7:0] reg_rdata, // Read data
    input wire reg_rvalid, // Read valid
    input wire [2:0] gain_prog, // Programmed gain
    input wire [2:0] gain_eff, // Effective gain
    input wire mux_open, // Input switches open
    input wire [2:0] system_monitor_select, // Monitor code
    input wire [4:0] calibration_sample_count, // Calibration samples
    input wire timeout_enable, // Timeout on
    input wire conv_restart, // Restart pulse
    input wire [3:0] pin_oe_n, // Pin drive, low drives
    input wire [3:0] pin_function // Pin digital select
);
    // ****************************************
    // Relations at the ports
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire sup_mon = system_monitor_select == 3'h3 || system_monitor_select == 3'h4;
    wire cfg_wr = reg_wr && reg_addr >= 8'h05 && reg_addr <= 8'h09;
    sequence s_sys_wr;
        reg_wr && reg_addr == 8'h09 ##1 1'b1;
    endsequence
    sequence s_spare_rd;
        reg_rd && (reg_addr == 8'h0a || reg_addr == 8'h0d) ##1 reg_rvalid;
    endsequence
    a_read_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered next cycle");
    a_read_quiet: assert property (!reg_rd |=> !reg_rvalid)
        else $error("read valid without read");
    a_restart_pulse: assert property (cfg_wr |=> conv_restart)
        else $error("no restart after configuration write");
    a_restart_quiet: assert property (!cfg_wr |=> !conv_restart)
        else $error("restart without configuration write");
    a_sys_write: assert property (s_sys_wr |-> {system_monitor_select, 2'h0, timeout_enable, 2'h0}
        == ($past(reg_wdata) & 8'he4))
        else $error("system control write not applied");
    a_spare_zero: assert property (s_spare_rd |-> reg_rdata == 8'h00)
        else $error("reserved register read nonzero");
    a_gain_forced: assert property (sup_mon |-> gain_eff == 3'h0)
        else $error("gain not forced to one");
    a_gain_pass: assert property (!sup_mon |-> gain_eff == gain_prog)
        else $error("gain not passed through");
    a_mux_open: assert property (mux_open == (system_monitor_select inside {[3'h1:3'h4]}))
        else $error("input switch state wrong");
    a_pin_drive: assert property ((pin_oe_n | pin_function) == 4'hf)
        else $error("analog pin driven");
    a_cal_count: assert property (calibration_sample_count inside {5'h01, 5'h04, 5'h08, 5'h10})
        else $error("illegal sample count");
endmodule

// ---- verif/aucr_host.sv ----
// Host model issuing register read and write commands
`timescale 1ns/1ps
module aucr_host (
    input wire clk, // Clock
    input wire [7:0] reg_rdata, // Read data
    input wire reg_rvalid, // Read valid
    output reg reg_wr, // Write strobe
    output reg reg_rd, // Read strobe
    output reg [7:0] reg_addr, // Address
    output reg [7:0] reg_wdata // Write data
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // Released address and data show the inverse of the last value
    task wr(input [7:0] a, input [7:0] d);
        begin
            reg_addr = a;
            reg_wdata = d;
            reg_wr = 1'b1;
            @(posedge clk);
            #1;
            reg_wr = 1'b0;
            reg_addr = ~a;
            reg_wdata = ~d;
            @(posedge clk);
            #1;
        end
    endtask
    task rd(input [7:0] a, output [7:0] d, output v);
        begin
            reg_addr = a;
            reg_rd = 1'b1;
            @(posedge clk);
            #1;
            // Valid stands for the one cycle after the taking edge
            d = reg_rdata;
            v = reg_rvalid;
            reg_rd = 1'b0;
            reg_addr = ~a;
            @(posedge clk);
            #1;
        end
    endtask
endmodule

// ---- verif/aucr_regs_test.sv ----
// Self-checking bench of the upper configuration register bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done = checks_done + 1; if ((g) !== (e)) begin \
    n_mismatch = n_mismatch + 1; $display("wrong value %s expected %h seen %h", nm, e, g); end end
module aucr_regs_test;
    reg clk, reset_n, v;
    reg [2:0] gain_prog;
    reg [3:0] pin_in;
    reg [7:0] d;
    integer i;
    integer n_mismatch = 0;
    integer checks_done = 0;
    wire reg_wr, reg_rd, reg_rvalid, mux_open, ref_monitor_enable, pos_ref_buffer_bypass;
    wire neg_ref_buffer_bypass, timeout_enable, conv_restart;
    wire [7:0] reg_addr, reg_wdata, reg_rdata;
    wire [2:0] gain_eff, system_monitor_select;
    wire [1:0] ref_source_select, internal_ref_config;
    wire [3:0] current_magnitude, first_current_route, second_current_route;
    wire [3:0] pin_out, pin_oe_n, pin_function;
    wire [6:0] bias_voltage;
    wire [4:0] calibration_sample_count;
    wire [15:0] offset_trim_value, gain_trim_value;
    localparam [111:0] RST = 112'h10_00_ff_00_10_00_00_00_00_00_40_00_00_00;
    localparam [111:0] WD = 112'hfa_ff_5a_ff_5f_ff_34_12_ff_78_56_f5_ff_ff;
    localparam [111:0] EX = 112'h7a_0f_5a_7f_5c_00_34_12_00_78_56_fa_0f_00;
    aucr_host host (.clk(clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    aucr_regs uut (.clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .gain_prog(gain_prog), .gain_eff(gain_eff),
        .mux_open(mux_open), .ref_monitor_enable(ref_monitor_enable),
        .pos_ref_buffer_bypass(pos_ref_buffer_bypass),
        .neg_ref_buffer_bypass(neg_ref_buffer_bypass), .ref_source_select(ref_source_select),
        .internal_ref_config(internal_ref_config), .current_magnitude(current_magnitude),
        .first_current_route(first_current_route), .second_current_route(second_current_route),
        .bias_voltage(bias_voltage), .system_monitor_select(system_monitor_select),
        .calibration_sample_count(calibration_sample_count), .timeout_enable(timeout_enable),
        .offset_trim_value(offset_trim_value), .gain_trim_value(gain_trim_value),
        .conv_restart(conv_restart), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pin_function(pin_function));
    task test_done;
        begin
            $display("checks %0d mismatches %0d", checks_done, n_mismatch);
            if (n_mismatch == 0 && checks_done > 0) begin
                $display("No errors found");
            end else begin
                $display("Errors were found");
            end
            $finish;
        end
    endtask
    task chk_rd(input [7:0] a, input [7:0] e);
        begin
            host.rd(a, d, v);
            `CHK("read valid", 1'b1, v)
            `CHK("read data", e, d)
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #200000;
        n_mismatch = n_mismatch + 1;
        $display("timeout");
        test_done;
    end
    initial begin
        reset_n = 1'b0;
        gain_prog = 3'h2;
        pin_in = 4'ha;
        repeat (8) @(posedge clk);
        #1;
        reset_n = 1'b1;
        // ****************************************
        // Reset values
        // ****************************************
        `CHK("cal count", 5'h08, calibration_sample_count)
        `CHK("pin drive", 4'hf, pin_oe_n)
        for (i = 0; i < 14; i = i + 1) begin
            chk_rd(8'h05 + i[7:0], RST[8 * (13 - i) +: 8]);
        end
        $display("test reset_values done");
        // ****************************************
        // Write every place, read back
        // ****************************************
        for (i = 0; i < 14; i = i + 1) begin
            host.wr(8'h05 + i[7:0], WD[8 * (13 - i) +: 8]);
        end
        for (i = 0; i < 14; i = i + 1) begin
            chk_rd(8'h05 + i[7:0], EX[8 * (13 - i) +: 8]);
        end
        `CHK("ref", 7'h7a, {ref_monitor_enable, pos_ref_buffer_bypass, neg_ref_buffer_bypass, ref_source_select, internal_ref_config})
        `CHK("current", 12'hf5a, {current_magnitude, second_current_route, first_current_route})
        `CHK("bias", 7'h7f, bias_voltage)
        `CHK("sys", 9'h0a1, {system_monitor_select, calibration_sample_count, timeout_enable})
        `CHK("trims", 32'h12345678, {offset_trim_value, gain_trim_value})
        `CHK("pins", 8'hff, {pin_function, pin_oe_n})
        $display("test write_readback done");
        for (i = 0; i < 8; i = i + 1) begin
            host.wr(8'h09, {i[2:0], 5'h10});
            `CHK("monitor", i[2:0], system_monitor_select)
            `CHK("mux open", (i >= 1 && i <= 4), mux_open)
            `CHK("gain", (i == 3 || i == 4) ? 3'h0 : 3'h2, gain_eff)
        end
        for (i = 0; i < 4; i = i + 1) begin
            host.wr(8'h09, {3'h0, i[1:0], 3'h0});
            `CHK("cal count", (i == 0) ? 5'h01 : 5'h02 << i, calibration_sample_count)
        end
        $display("test monitor_codes done");
        host.wr(8'h10, 8'h35);
        `CHK("pin out", 8'h53, {pin_out, pin_oe_n})
        chk_rd(8'h10, 8'h36);
        pin_in = 4'h5;
        chk_rd(8'h10, 8'h35);
        host.wr(8'h11, 8'h00);
        `CHK("pin drive", 4'hf, pin_oe_n)
        $display("test pins done");
        test_done;
    end
endmodule
bind aucr_regs aucr_regs_monitor mon (.clk(clk), .reset_n(reset_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .gain_prog(gain_prog), .gain_eff(gain_eff), .mux_open(mux_open),
    .system_monitor_select(system_monitor_select), .timeout_enable(timeout_enable),
    .calibration_sample_count(calibration_sample_count), .conv_restart(conv_restart),
    .pin_oe_n(pin_oe_n), .pin_function(pin_function));
